// [src/lsp_regs.svh]
`ifndef LSP_REGS_SVH
`define LSP_REGS_SVH
// Operation
// - Two-wire traffic is served only while the deselect input is held low.
// - Interrupt output signals an important condition readable over two-wire; the code raises it for a pending condition only in run.
// - Transmitter laser is off while transmit-disable is asserted.
// - Absence output is tied low inside the module.
// - Not-ready output reports an internal operational fault.
// - Receive loss-of-signal output reports a lost incoming signal.
// - Power-down input high puts the module into low power, 1.5W at most.
// - Two-wire management keeps working in the low-power state.
// - Falling edge of power-down/reset causes a complete reset, two-wire included.
// - With deselect high, no two-wire transfer is answered or acknowledged.
// - Leaving power-down causes a second reset and completion interrupt.
// - Initialization finishes within 300 ms of power-on or reset edge.

// Input filter length in clock cycles
`define LSP_FILT_CYCLES 4
// Initialization time in ms and derived cycle count at 100 MHz
`define LSP_T_INIT_MS 300
`define LSP_CLK_KHZ 100000
`define LSP_INIT_CYCLES (`LSP_T_INIT_MS * `LSP_CLK_KHZ)
`endif

// [src/lsp_pkg.sv]
package lsp_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_INIT = 4'h2,
        ST_RUN = 4'h4,
        ST_LOWPWR = 4'h8
    } lsp_state_t;
endpackage : lsp_pkg

// [src/lsp_filt_if.sv]
`timescale 1ns/1ps
interface lsp_filt_if;
    logic raw;
    logic level;
    logic fall;
    modport filt (input raw, output level, output fall);
    modport user (output raw, input level, input fall);
endinterface : lsp_filt_if

// [src/lsp_input_filter.sv]
`timescale 1ns/1ps
`include "lsp_regs.svh"
module lsp_input_filter #(
    parameter int FILT = `LSP_FILT_CYCLES,
    parameter logic INIT = 1'b1
) (
    input wire logic mclk,
    input wire logic rstn,
    lsp_filt_if.filt p
);
    logic s1_q, s1_d, s2_q, s2_d, lvl_q, lvl_d, fall_q, fall_d;
    logic [7:0] cnt_q, cnt_d;

    // Two-stage synchroniser, then level must hold FILT cycles
    always_comb begin
        s1_d = p.raw;
        s2_d = s1_q;
        lvl_d = lvl_q;
        cnt_d = 8'h00;
        fall_d = 1'b0;
        if (s2_q != lvl_q) begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == 8'(FILT - 1)) begin
                lvl_d = s2_q;
                cnt_d = 8'h00;
                fall_d = lvl_q & ~s2_q;
            end
        end
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_q <= INIT;
            s2_q <= INIT;
            lvl_q <= INIT;
            cnt_q <= 8'h00;
            fall_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
            fall_q <= fall_d;
        end
    end

    assign p.level = lvl_q;
    assign p.fall = fall_q;
endmodule : lsp_input_filter

// [src/lsp_pins.sv]
`timescale 1ns/1ps
`include "lsp_regs.svh"
module lsp_pins
    import lsp_pkg::*;
#(
    parameter int INIT_CYCLES = `LSP_INIT_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic module_deselect_input,
    input wire logic tx_disable,
    input wire logic power_down_reset,
    input wire logic fault_tx_lock,
    input wire logic fault_laser,
    input wire logic fault_rx_lock,
    input wire logic rx_signal_lost,
    input wire logic condition_pending,
    output logic absent_oe,
    output logic module_not_ready_oe,
    output logic rx_los_oe,
    output logic irq_n_oe,
    output logic laser_enable,
    output logic low_power,
    output logic twi_enable,
    output logic twi_reset,
    output logic reset_done_pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and filters
    lsp_filt_if desel_if();
    lsp_filt_if txdis_if();
    lsp_filt_if pdn_if();
    assign desel_if.raw = module_deselect_input;
    assign txdis_if.raw = tx_disable;
    assign pdn_if.raw = power_down_reset;

    // Deselect idles high through the in-module pull-up
    lsp_input_filter #(
        .FILT(`LSP_FILT_CYCLES),
        .INIT(1'b1)
    ) u_desel (
        .mclk(mclk),
        .rstn(rstn),
        .p(desel_if.filt)
    );
    // Transmit-disable idles high, so the laser starts off
    lsp_input_filter #(
        .FILT(`LSP_FILT_CYCLES),
        .INIT(1'b1)
    ) u_txdis (
        .mclk(mclk),
        .rstn(rstn),
        .p(txdis_if.filt)
    );
    // Power-down idles high; its falling edge is the reset request
    lsp_input_filter #(
        .FILT(`LSP_FILT_CYCLES),
        .INIT(1'b1)
    ) u_pdn (
        .mclk(mclk),
        .rstn(rstn),
        .p(pdn_if.filt)
    );

    // Fault sources come from logic on this clock and are read directly
    logic any_fault;
    assign any_fault = fault_tx_lock | fault_laser | fault_rx_lock;

    ////////////////////////////////////////////////////////////////////////
    // Reset / init / power state machine
    lsp_state_t state_q, state_d;
    logic [31:0] init_cnt_q, init_cnt_d;
    logic irq_q, irq_d;
    logic done_q, done_d;

    // Next state: one reset cycle clears the counter, initialisation
    // counts INIT_CYCLES, then the module runs or stays in low power.
    // Low power is left only through a power-down falling edge, which
    // brings a second full reset and a second completion pulse.
    always_comb begin
        state_d = state_q;
        init_cnt_d = init_cnt_q;
        done_d = 1'b0;
        case (state_q)
            ST_RESET: begin
                init_cnt_d = 32'h0;
                state_d = ST_INIT;
            end
            ST_INIT: begin
                init_cnt_d = init_cnt_q + 32'h1;
                if (init_cnt_q >= 32'(INIT_CYCLES - 1)) begin
                    done_d = 1'b1;
                    state_d = pdn_if.level ? ST_LOWPWR : ST_RUN;
                end
            end
            ST_RUN: begin
                if (pdn_if.level) begin
                    state_d = ST_LOWPWR;
                end
            end
            ST_LOWPWR: begin
                state_d = ST_LOWPWR;
            end
            default: state_d = ST_RESET;
        endcase
        // Falling edge of power-down/reset restarts everything; a cut
        // initialisation must not report completion
        if (pdn_if.fall) begin
            state_d = ST_RESET;
            done_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= ST_RESET;
            init_cnt_q <= 32'h0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            init_cnt_q <= init_cnt_d;
            done_q <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: reset completion first, then pending conditions in run
    always_comb begin
        irq_d = irq_q;
        if (pdn_if.fall) begin
            // A restart withdraws whatever the line was showing
            irq_d = 1'b0;
        end else if (done_d) begin
            // Completion of reset is the only source in low power
            irq_d = 1'b1;
        end else if (state_q == ST_RUN && condition_pending) begin
            irq_d = 1'b1;
        end else if (!condition_pending && !done_q &&
            (state_q == ST_RUN || state_q == ST_LOWPWR)) begin
            // The host has read and cleared the flag behind the line
            irq_d = 1'b0;
        end
    end

    // Interrupt register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin outputs
    logic running;
    logic twi_held;
    logic absent_oe_d, not_ready_oe_d, rx_los_oe_d, irq_n_oe_d;
    logic laser_enable_d, low_power_d, twi_enable_d, twi_reset_d;
    logic reset_done_pulse_d;
    assign running = (state_q == ST_RUN);
    assign twi_held = (state_q == ST_RESET) || (state_q == ST_INIT);

    // Next pin values; an open-collector line is pulled low while its
    // enable is high and reads high through the host pull-up otherwise
    always_comb begin
        absent_oe_d = 1'b1;
        // Status is only meaningful in normal running, so it is masked
        // during reset, initialisation and low power
        not_ready_oe_d = ~(running & any_fault);
        rx_los_oe_d = ~(running & rx_signal_lost);
        irq_n_oe_d = irq_q;
        laser_enable_d = running & ~txdis_if.level;
        low_power_d = pdn_if.level | (state_q == ST_LOWPWR);
        // The two-wire side answers only while selected and initialised
        twi_enable_d = ~desel_if.level &
            (state_q == ST_RUN || state_q == ST_LOWPWR);
        // Keep the two-wire side in reset until initialisation ends
        twi_reset_d = twi_held;
        reset_done_pulse_d = done_q;
    end

    // Output registers; reset shows absence driven and the two-wire side held in reset, everything else quiet
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            absent_oe <= 1'b1;
            module_not_ready_oe <= 1'b0;
            rx_los_oe <= 1'b0;
            irq_n_oe <= 1'b0;
            laser_enable <= 1'b0;
            low_power <= 1'b0;
            twi_enable <= 1'b0;
            twi_reset <= 1'b1;
            reset_done_pulse <= 1'b0;
        end else begin
            absent_oe <= absent_oe_d;
            module_not_ready_oe <= not_ready_oe_d;
            rx_los_oe <= rx_los_oe_d;
            irq_n_oe <= irq_n_oe_d;
            laser_enable <= laser_enable_d;
            low_power <= low_power_d;
            twi_enable <= twi_enable_d;
            twi_reset <= twi_reset_d;
            reset_done_pulse <= reset_done_pulse_d;
        end
    end
endmodule : lsp_pins

// [verif/lsp_pins_checker.sv]
`timescale 1ns/1ps
module lsp_pins_checker #(
    parameter int INIT_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic module_deselect_input,
    input wire logic tx_disable,
    input wire logic power_down_reset,
    input wire logic fault_tx_lock,
    input wire logic fault_laser,
    input wire logic fault_rx_lock,
    input wire logic absent_oe,
    input wire logic module_not_ready_oe,
    input wire logic irq_n_oe,
    input wire logic laser_enable,
    input wire logic low_power,
    input wire logic twi_enable,
    input wire logic twi_reset,
    input wire logic reset_done_pulse
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic [31:0] init_q;
    logic [31:0] init_d;
    logic run;
    // Cycles spent with the two-wire side held in reset
    assign init_d = twi_reset ? init_q + 32'h1 : 32'h0;
    assign run = twi_enable && !low_power && !twi_reset;
    always_ff @(posedge mclk) begin
        init_q <= rstn ? init_d : 32'h0;
    end
    sequence pdn_fall_s;
        $fell(power_down_reset) ##1 (!power_down_reset)[*8];
    endsequence
    a_absent_tied: assert property (absent_oe)
        else $error("absence pin released");
    a_laser_off: assert property (tx_disable[*8] ##1 tx_disable[*2]
        |-> !laser_enable) else $error("laser on while disabled");
    a_deselect_mutes: assert property (module_deselect_input[*8]
        ##1 module_deselect_input[*2] |-> !twi_enable) else $error("twi on");
    a_reset_on_fall: assert property (pdn_fall_s |-> ##[0:4] twi_reset)
        else $error("no reset after falling edge");
    a_twi_low_power: assert property ((low_power && power_down_reset &&
        !twi_reset && !module_deselect_input)[*8] |=> twi_enable)
        else $error("twi off");
    a_done_raises_irq: assert property (reset_done_pulse
        |-> ##[0:2] irq_n_oe) else $error("no completion interrupt");
    a_init_bounded: assert property (init_q <= INIT_CYCLES + 4)
        else $error("init too long");
    a_fault_not_ready: assert property ((run && (fault_tx_lock ||
        fault_laser || fault_rx_lock))[*4] |-> !module_not_ready_oe)
        else $error("fault not reported");
endmodule : lsp_pins_checker
bind lsp_pins lsp_pins_checker #(.INIT_CYCLES(INIT_CYCLES)) chk (.*);

// [verif/lsp_host_model.sv]
`timescale 1ns/1ps
module lsp_host_model (
    input wire logic absent_oe,
    input wire logic module_not_ready_oe,
    input wire logic rx_los_oe,
    output logic absent_pin,
    output logic not_ready_pin,
    output logic rx_los_pin
);
    // Host pull-ups: a line reads high unless the module pulls it low
    assign absent_pin = !absent_oe;
    assign not_ready_pin = !module_not_ready_oe;
    assign rx_los_pin = !rx_los_oe;
endmodule : lsp_host_model

// [verif/lsp_pins_tb_top.sv]
`timescale 1ns/1ps
module lsp_pins_tb_top;
    `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
        mismatches++; $display("wrong value %s exp %b got %b", n, e, g); \
        end end
    logic mclk = 1'b0;
    logic rstn, module_deselect_input, tx_disable, power_down_reset;
    logic fault_tx_lock, fault_laser, fault_rx_lock;
    logic rx_signal_lost, condition_pending, absent_oe, module_not_ready_oe;
    logic rx_los_oe, irq_n_oe, laser_enable, low_power, twi_enable;
    logic twi_reset, reset_done_pulse, absent_pin, not_ready_pin, rx_los_pin;
    int mismatches = 0;
    int samples_checked = 0;
    lsp_pins #(.INIT_CYCLES(20)) dut (.*);
    lsp_host_model host (.*);
    // Free-running 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Bounded wait for the end of initialisation
    task automatic wait_done;
        int i;
        for (i = 0; i < 100 && reset_done_pulse !== 1'b1; i++) begin
            @(negedge mclk);
        end
        if (i == 100) begin
            mismatches++;
            wrap_up();
        end
    endtask : wait_done
    // Main sequence, inputs change on the falling edge
    initial begin
        rstn = 1'b0;
        {module_deselect_input, tx_disable, power_down_reset} = 3'h7;
        {fault_tx_lock, fault_laser, fault_rx_lock} = 3'h0;
        rx_signal_lost = 1'b0;
        condition_pending = 1'b1;
        step(10);
        rstn = 1'b1;
        step(60);
        `CHK("low_power", 1'b1, low_power)
        `CHK("absent_pin", 1'b0, absent_pin)
        `CHK("twi_muted", 1'b0, twi_enable)
        module_deselect_input = 1'b0;
        step(12);
        `CHK("twi_low_power", 1'b1, twi_enable)
        power_down_reset = 1'b0;
        wait_done();
        `CHK("irq_done", 1'b1, irq_n_oe)
        condition_pending = 1'b0;
        step(4);
        `CHK("irq_clear", 1'b0, irq_n_oe)
        `CHK("awake", 1'b0, low_power)
        `CHK("twi_run", 1'b1, twi_enable)
        tx_disable = 1'b0;
        step(12);
        tx_disable = 1'b1;
        step(2);
        tx_disable = 1'b0;
        step(7);
        `CHK("laser_glitch", 1'b1, laser_enable)
        tx_disable = 1'b1;
        step(12);
        `CHK("laser_off", 1'b0, laser_enable)
        for (int k = 0; k < 3; k++) begin
            {fault_tx_lock, fault_laser, fault_rx_lock} = 3'h1 << k;
            step(4);
            `CHK("not_ready", 1'b1, not_ready_pin)
            {fault_tx_lock, fault_laser, fault_rx_lock} = 3'h0;
            step(4);
            `CHK("ready", 1'b0, not_ready_pin)
        end
        rx_signal_lost = 1'b1;
        step(4);
        `CHK("los_pin", 1'b1, rx_los_pin)
        module_deselect_input = 1'b1;
        power_down_reset = 1'b1;
        step(12);
        `CHK("twi_muted", 1'b0, twi_enable)
        `CHK("low_power", 1'b1, low_power)
        wrap_up();
    end
endmodule : lsp_pins_tb_top
